// [orientation_state_report.sv]
// Orientation status and setup registers with change flag and debounce.
// Assumes the serial interface front end delivers one-cycle read and write
// strobes, and the angle logic delivers a raw orientation once per sample.
//
// Summary of operation
// - Change flag bit 7 sets on state change.
// - Flag sets after first determination once running.
// - Reading status register clears change flag.
// - Flag rising edge clears auto-wake/sleep timer.
// - Event source bit shows pending change event.
// - Bit 6 reads tilt lockout condition.
// - Bits 2:1 encode portrait/landscape state.
// - Bit 0: 0 front, 1 back.
// - State fields keep tracking while flag set.
// - Reset zeroes back/front and portrait/landscape.
// - Leaving standby clears back/front and portrait/landscape.
// - Orientation held while any axis above 1.25g.
// - Mode 0 decrements debounce count on change.
// - Mode 1 clears debounce count on change.
// - Enable bit 6 turns function on; default off.
// - New orientation persists programmed samples before flag.
// - Debounce resets on standby entry/exit and wake/sleep changes.
// - Debounce count frozen while above 1.25g.
`timescale 1ns/1ns
`default_nettype none
module orientation_state_report (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire orient_pkg::reg_req_s reg_req_i,
    output logic [7:0] reg_rdata_o,
    input wire logic sample_i,
    input wire orient_pkg::orient_s orient_raw_i,
    input wire logic over_range_i,
    input wire orient_pkg::op_mode_e op_mode_i,
    input wire logic aws_state_i,
    input wire logic [7:0] orientation_debounce_count_i,
    output logic [7:0] status_o,
    output logic orientation_event_source_o,
    output logic aws_timer_clear_o,
    output logic orientation_detect_enable_o
);
    import orient_pkg::*;

    // Builds the status byte; unused bits 5:3 read as zero.
    function automatic logic [7:0] status_byte(input logic flag, input orient_s st);
        logic [7:0] b;
        b = STATUS_RESET;
        b[STAT_FLAG_BIT] = flag;
        b[STAT_LOCK_BIT] = st.tilt_lockout;
        b[STAT_PL_LSB +: 2] = st.portrait_landscape_state;
        b[STAT_BF_BIT] = st.back_front_state;
        return b;
    endfunction : status_byte

    logic [7:0] setup_reg;
    logic [7:0] rdata_reg;
    orient_s orient_reg;
    orient_s raw_prev_reg;
    logic flag_reg;
    logic first_pending_reg;
    logic aws_clear_reg;
    op_mode_e mode_prev_reg;
    logic aws_prev_reg;

    logic enable;
    logic clear_mode;
    logic enter_run;
    logic leave_run;
    logic aws_change;
    logic running;
    logic evaluate;
    logic restart;
    logic differ;
    logic match;
    logic done;
    logic accept;
    logic flag_set;
    logic rd_status;
    logic wr_setup;
    logic [7:0] count;

    assign enable = setup_reg[SETUP_EN_BIT];
    assign clear_mode = setup_reg[SETUP_MODE_BIT];
    assign rd_status = reg_req_i.rd && reg_req_i.addr == ADDR_STATUS;
    assign wr_setup = reg_req_i.wr && reg_req_i.addr == ADDR_SETUP;

    // Mode edges are taken from the previous cycle's mode.
    assign enter_run = mode_prev_reg == MODE_STANDBY && op_mode_i != MODE_STANDBY;
    assign leave_run = mode_prev_reg != MODE_STANDBY && op_mode_i == MODE_STANDBY;
    assign aws_change = aws_state_i != aws_prev_reg;
    assign running = mode_prev_reg != MODE_STANDBY && op_mode_i != MODE_STANDBY;

    // A disabled function restarts the debounce so that enabling starts clean.
    assign restart = enter_run || leave_run || aws_change || !enable;

    // Samples above the 1.25g limit are not evaluated at all.
    assign evaluate = sample_i && enable && running && !over_range_i;

    assign differ = orient_raw_i != orient_reg;
    assign match = orient_raw_i == raw_prev_reg;

    orient_debounce u_debounce (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .restart_i(restart),
        .sample_i(sample_i && enable && running),
        .freeze_i(over_range_i),
        .differ_i(differ),
        .match_i(match),
        .clear_mode_i(clear_mode),
        .limit_i(orientation_debounce_count_i),
        .count_o(count),
        .done_o(done)
    );

    // The first determination after leaving standby is taken without debounce.
    assign accept = evaluate && (first_pending_reg || done);
    assign flag_set = accept;

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            mode_prev_reg <= MODE_STANDBY;
            aws_prev_reg <= 1'b0;
        end else begin
            mode_prev_reg <= op_mode_i;
            aws_prev_reg <= aws_state_i;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            setup_reg <= SETUP_RESET;
        end else if (wr_setup) begin
            setup_reg <= reg_req_i.wdata;
        end
    end

    // Reported orientation; fields follow accepted changes even with the flag set.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            orient_reg <= ORIENT_RESET;
        end else if (enter_run) begin
            orient_reg.portrait_landscape_state <= PL_PORTRAIT_UP;
            orient_reg.back_front_state <= BF_FRONT;
        end else if (accept) begin
            orient_reg <= orient_raw_i;
        end
    end

    // Previous raw sample, used to see whether a candidate holds steady.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            raw_prev_reg <= ORIENT_RESET;
        end else if (evaluate) begin
            raw_prev_reg <= orient_raw_i;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            first_pending_reg <= 1'b0;
        end else if (enter_run) begin
            first_pending_reg <= 1'b1;
        end else if (evaluate) begin
            first_pending_reg <= 1'b0;
        end
    end

    // A change that lands in the same cycle as a status read is kept.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            flag_reg <= 1'b0;
        end else if (flag_set) begin
            flag_reg <= 1'b1;
        end else if (rd_status) begin
            flag_reg <= 1'b0;
        end
    end

    // Registered pulse aligned with the cycle the flag first reads high.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            aws_clear_reg <= 1'b0;
        end else begin
            aws_clear_reg <= flag_set && !flag_reg;
        end
    end

    // Read data is registered; bus answer is valid one cycle after the strobe.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            rdata_reg <= RDATA_RESET;
        end else if (reg_req_i.rd) begin
            unique case (reg_req_i.addr)
                ADDR_STATUS: rdata_reg <= status_byte(flag_reg, orient_reg);
                ADDR_SETUP: rdata_reg <= setup_reg;
                default: rdata_reg <= RDATA_RESET;
            endcase
        end
    end

    assign reg_rdata_o = rdata_reg;
    assign status_o = status_byte(flag_reg, orient_reg);
    assign orientation_event_source_o = flag_reg;
    assign aws_timer_clear_o = aws_clear_reg;
    assign orientation_detect_enable_o = enable;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_leave_standby;
        mode_prev_reg == MODE_STANDBY ##1 op_mode_i != MODE_STANDBY;
    endsequence

    sequence s_first_eval;
        first_pending_reg && evaluate;
    endsequence

    sequence s_stable_change;
        evaluate && differ && match && !first_pending_reg && !aws_change &&
            {1'b0, count} + 9'h001 >= {1'b0, orientation_debounce_count_i};
    endsequence

    change_flag_a: assert property (evaluate && differ && done |=> flag_reg && orient_reg == $past(orient_raw_i))
        else $error("Accepted change did not set the flag.");

    first_flag_a: assert property (s_leave_standby ##0 (!evaluate) [*1] ##[0:300] s_first_eval |=> flag_reg)
        else $error("First determination did not set the flag.");

    read_clear_a: assert property (rd_status && !flag_set |=> !flag_reg ##0 reg_rdata_o[7] == $past(flag_reg))
        else $error("Status read did not clear the flag.");

    aws_edge_a: assert property (aws_timer_clear_o == (flag_reg && !$past(flag_reg)))
        else $error("Wake/sleep clear not tied to flag edge.");

    source_tie_a: assert property ($rose(flag_reg) |-> orientation_event_source_o && status_o[7])
        else $error("Event source bit not set with the flag.");

    standby_clear_a: assert property (enter_run |=> status_o[2:0] == 3'h0)
        else $error("Leaving standby did not clear the states.");

    range_hold_a: assert property (over_range_i && !enter_run |=> $stable(orient_reg))
        else $error("Orientation moved above the range limit.");

    debounce_wait_a: assert property (s_stable_change |=> flag_reg)
        else $error("Stable orientation not accepted at its count.");

    disabled_quiet_a: assert property (!enable && !enter_run |=> $stable(orient_reg) && !$rose(flag_reg))
        else $error("Disabled function changed the orientation.");

    flag_hold_a: assert property (flag_reg && !rd_status |=> flag_reg)
        else $error("Flag dropped without a status read.");

endmodule : orientation_state_report
`default_nettype wire

// [orient_pkg.sv]
// Shared constants and types for the orientation status and setup logic.
// Assumes the register port and sample strobe run on the single system clock.
package orient_pkg;

    // Register offsets.
    localparam logic [7:0] ADDR_STATUS = 8'h28;
    localparam logic [7:0] ADDR_SETUP = 8'h29;

    // Status register field positions.
    localparam int STAT_FLAG_BIT = 7;
    localparam int STAT_LOCK_BIT = 6;
    localparam int STAT_PL_LSB = 1;
    localparam int STAT_BF_BIT = 0;

    // Setup register field positions and values after reset.
    localparam int SETUP_MODE_BIT = 7;
    localparam int SETUP_EN_BIT = 6;
    localparam logic [7:0] SETUP_RESET = 8'h80;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] RDATA_RESET = 8'h00;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] COUNT_MAX = 8'hff;

    // Portrait/landscape encodings.
    localparam logic [1:0] PL_PORTRAIT_UP = 2'h0;
    localparam logic [1:0] PL_PORTRAIT_DOWN = 2'h1;
    localparam logic [1:0] PL_LANDSCAPE_RIGHT = 2'h2;
    localparam logic [1:0] PL_LANDSCAPE_LEFT = 2'h3;

    // Back/front encodings.
    localparam logic BF_FRONT = 1'b0;
    localparam logic BF_BACK = 1'b1;

    typedef struct packed {
        logic tilt_lockout;
        logic [1:0] portrait_landscape_state;
        logic back_front_state;
    } orient_s;

    localparam orient_s ORIENT_RESET = '{1'b0, PL_PORTRAIT_UP, BF_FRONT};

    typedef enum logic [1:0] {
        MODE_STANDBY,
        MODE_ACTIVE,
        MODE_EXT_TRIGGER
    } op_mode_e;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

endpackage : orient_pkg

// [orient_debounce.sv]
// Orientation debounce counter: counts samples of a stable new orientation.
// Assumes sample_i is a one-cycle strobe per output-data-rate period.
`timescale 1ns/1ns
`default_nettype none
module orient_debounce (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic restart_i,
    input wire logic sample_i,
    input wire logic freeze_i,
    input wire logic differ_i,
    input wire logic match_i,
    input wire logic clear_mode_i,
    input wire logic [7:0] limit_i,
    output logic [7:0] count_o,
    output logic done_o
);
    import orient_pkg::*;

    logic [7:0] count_reg;
    logic [8:0] count_inc;
    logic step;

    assign step = sample_i && !freeze_i && !restart_i;
    assign count_inc = {1'b0, count_reg} + 9'h001;
    assign count_o = count_reg;
    // A limit of zero accepts a new orientation on its first sample.
    assign done_o = step && differ_i &&
        ((match_i && count_inc >= {1'b0, limit_i}) || limit_i == COUNT_RESET);

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i || restart_i) begin
            count_reg <= COUNT_RESET;
        end else if (step) begin
            if (!differ_i) begin
                count_reg <= COUNT_RESET;
            end else if (!match_i) begin
                if (clear_mode_i || count_reg == COUNT_RESET) begin
                    count_reg <= COUNT_RESET;
                end else begin
                    count_reg <= count_reg - 8'h01;
                end
            end else if (count_reg != COUNT_MAX) begin
                count_reg <= count_inc[7:0];
            end
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    hold_freeze_a: assert property (sample_i && freeze_i && !restart_i |=> $stable(count_reg))
        else $error("Debounce count moved while frozen.");
    clear_mode_a: assert property (step && differ_i && !match_i && clear_mode_i |=> count_reg == 8'h00)
        else $error("Debounce count not cleared on change.");
    decrement_mode_a: assert property (step && differ_i && !match_i && !clear_mode_i && count_reg != 8'h00
        |=> count_reg == $past(count_reg) - 8'h01)
        else $error("Debounce count not decremented on change.");
    restart_clear_a: assert property (restart_i |=> count_reg == 8'h00)
        else $error("Debounce count not reset on restart.");

endmodule : orient_debounce
`default_nettype wire

// [host_reg_model.sv]
// Host processor model: issues single-byte register writes and reads.
// Assumes the register port takes one-cycle strobes and answers a read one cycle later.
`timescale 1ns/1ns
`default_nettype none
module host_reg_model (
    input wire logic clk_sys_i,
    input wire logic [7:0] reg_rdata_i,
    output var orient_pkg::reg_req_s reg_req_o
);
    import orient_pkg::*;

    initial reg_req_o = '0;

    // Requests change only after a falling edge, so the taking edge sees them settled.
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clk_sys_i);
        reg_req_o = '{1'b1, 1'b0, addr, data};
        @(negedge clk_sys_i);
        reg_req_o = '0;
    endtask : wr

    task automatic rd(input logic [7:0] addr, output logic [7:0] data);
        @(negedge clk_sys_i);
        reg_req_o = '{1'b0, 1'b1, addr, 8'h00};
        @(negedge clk_sys_i);
        reg_req_o = '0;
        data = reg_rdata_i;
    endtask : rd

endmodule : host_reg_model
`default_nettype wire

// [tb_orientation_detect_status.sv]
// Self-checking bench for the orientation status block against a reference model.
// Assumes the host model drives the register port and this bench drives the sample path.
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin fails++; \
    $display("[ERR] %0t got %h expected %h", $time, (got), (exp)); end end
module tb_orientation_detect_status;
    import orient_pkg::*;
    localparam logic [7:0] LIMIT = 8'h03;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic sample_i = 1'b0;
    logic ovr = 1'b0;
    logic aws = 1'b0;
    orient_s raw = '0;
    op_mode_e mode = MODE_STANDBY;
    reg_req_s reg_req;
    logic [7:0] rdata, status, rd_val;
    logic [7:0] lim = LIMIT;
    logic src, aws_clr, en_o, flag_q;
    logic exp_flag = 1'b0;
    logic [3:0] cur = 4'h0;
    logic [3:0] o;
    logic [31:0] lf = 32'h0001_7528;
    int fails = 0;
    int n_tests = 0;
    int rises = 0;
    int pulses = 0;

    orientation_state_report dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_req_i(reg_req), .reg_rdata_o(rdata),
        .sample_i(sample_i), .orient_raw_i(raw), .over_range_i(ovr), .op_mode_i(mode), .aws_state_i(aws),
        .orientation_debounce_count_i(lim), .status_o(status), .orientation_event_source_o(src),
        .aws_timer_clear_o(aws_clr), .orientation_detect_enable_o(en_o));
    host_reg_model host (.clk_sys_i(clk_sys_i), .reg_rdata_i(rdata), .reg_req_o(reg_req));

    initial forever #20 clk_sys_i = ~clk_sys_i;

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    function automatic logic [7:0] mk(input logic f, input logic [3:0] v);
        return {f, v[3], 3'b000, v[2:0]};
    endfunction : mk

    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : stop_test

    task automatic smp(input logic [3:0] v, input logic over);
        @(negedge clk_sys_i);
        sample_i = 1'b1;
        raw = orient_s'(v);
        ovr = over;
        @(negedge clk_sys_i);
        sample_i = 1'b0;
    endtask : smp

    // Acceptance must land exactly on sample kx; k0 samples of v were already counted.
    task automatic push(input logic [3:0] v, input int k0, input int kx);
        int k;
        bit got;
        k = k0;
        got = 1'b0;
        while (!got && k < LIMIT + 2) begin
            smp(v, 1'b0);
            k++;
            if (status === mk(1'b1, v)) got = 1'b1;
            else `CHK(status, mk(exp_flag, cur))
        end
        `CHK(got && k == kx, 1'b1)
        cur = v;
        exp_flag = 1'b1;
    endtask : push

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        host.rd(a, rd_val);
        `CHK(rd_val, e)
    endtask : rd_chk

    task automatic rd_status;
        rd_chk(ADDR_STATUS, mk(exp_flag, cur));
        exp_flag = 1'b0;
        `CHK(status, mk(1'b0, cur))
    endtask : rd_status

    task automatic enter(input op_mode_e m, input logic [3:0] v);
        mode = m;
        @(negedge clk_sys_i);
        `CHK(status, mk(exp_flag, {cur[3], 3'b000}))
        smp(v, 1'b0);
        `CHK(status, mk(1'b1, v))
        cur = v;
        exp_flag = 1'b1;
    endtask : enter

    always @(posedge clk_sys_i) begin
        if (rst_n_i) `CHK(src, status[7])
        if (status[7] && !flag_q) rises++;
        if (aws_clr) pulses++;
        flag_q <= status[7];
    end

    initial begin
        repeat (20000) @(posedge clk_sys_i);
        fails++;
        $display("[ERR] %0t run did not complete", $time);
        stop_test();
    end

    initial begin
        repeat (6) @(negedge clk_sys_i);
        rst_n_i = 1'b1;
        `CHK(status, STATUS_RESET)
        `CHK(en_o, 1'b0)
        rd_chk(ADDR_SETUP, SETUP_RESET);
        rd_chk(8'h3f, 8'h00);
        mode = MODE_ACTIVE;
        repeat (3) smp(4'h5, 1'b0);
        `CHK(status, STATUS_RESET)
        mode = MODE_STANDBY;
        host.wr(ADDR_SETUP, 8'hc0);
        host.wr(ADDR_STATUS, 8'hff);
        rd_chk(ADDR_SETUP, 8'hc0);
        `CHK(en_o, 1'b1)
        rd_chk(ADDR_STATUS, STATUS_RESET);
        enter(MODE_ACTIVE, 4'hb);
        rd_status();
        // Walk every portrait/landscape code, leaving the flag set on even passes.
        for (int i = 0; i < 8; i++) begin
            lf = lfsr_next(lf);
            o = {lf[3], i[1:0], lf[0]};
            if (o == cur) o = o ^ 4'h8;
            push(o, 0, LIMIT + 1);
            if (i[0]) rd_status();
        end
        o = cur ^ 4'h6;
        repeat (2) smp(o, 1'b0);
        repeat (4) smp(o, 1'b1);
        `CHK(status, mk(exp_flag, cur))
        push(o, 2, LIMIT + 1);
        o = {~cur[3], 3'b101};
        repeat (2) smp(o, 1'b0);
        aws = ~aws;
        repeat (2) smp(o, 1'b0);
        `CHK(status, mk(exp_flag, cur))
        push(o, 2, LIMIT);
        rd_status();
        mode = MODE_STANDBY;
        repeat (2) @(negedge clk_sys_i);
        enter(MODE_EXT_TRIGGER, 4'h6);
        host.wr(ADDR_SETUP, 8'h40);
        rd_chk(ADDR_SETUP, 8'h40);
        o = cur ^ 4'h2;
        repeat (3) smp(o, 1'b0);
        `CHK(status, mk(exp_flag, cur))
        // A bounce to a third orientation only decrements, so it settles one sample early.
        o = cur ^ 4'h4;
        smp(o, 1'b0);
        push(o, 1, LIMIT);
        lim = 8'h00;
        push(cur ^ 4'h1, 0, 1);
        lim = LIMIT;
        host.wr(ADDR_SETUP, 8'h00);
        rd_status();
        repeat (5) smp(cur ^ 4'h3, 1'b0);
        `CHK(status, mk(1'b0, cur))
        `CHK(en_o, 1'b0)
        rst_n_i = 1'b0;
        repeat (2) @(negedge clk_sys_i);
        rst_n_i = 1'b1;
        `CHK(status, STATUS_RESET)
        rd_chk(ADDR_SETUP, SETUP_RESET);
        repeat (3) @(negedge clk_sys_i);
        `CHK(pulses, rises)
        stop_test();
    end

endmodule : tb_orientation_detect_status
`undef CHK
`default_nettype wire
